/* File: fbdiv_pkg.sv */
// Shared constants for the feedback divider block and its prescaler stage.
package fbdiv_pkg;

  // ==========================================================================
  // Register map: register index, byte address is four times the index.
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned IDX_W         = 8;
  localparam logic [7:0]  IDX_REF_LO    = 8'h11;
  localparam logic [7:0]  IDX_REF_HI    = 8'h12;
  localparam logic [7:0]  IDX_SWALLOW   = 8'h13;
  localparam logic [7:0]  IDX_MAIN_LO   = 8'h14;
  localparam logic [7:0]  IDX_MAIN_HI   = 8'h15;
  localparam logic [7:0]  IDX_CTRL      = 8'h16;
  localparam logic [7:0]  IDX_STATUS    = 8'h1F;

  // ==========================================================================
  // Field widths and positions.
  localparam int unsigned SWALLOW_W     = 6;
  localparam int unsigned MAIN_W        = 13;
  localparam int unsigned MAIN_LO_W     = 8;
  localparam int unsigned MAIN_HI_W     = 5;
  localparam int unsigned REF_W         = 14;
  localparam int unsigned REF_LO_W      = 8;
  localparam int unsigned REF_HI_W      = 6;
  localparam int unsigned PSC_CNT_W     = 6;
  localparam int unsigned CTRL_W        = 8;
  localparam int unsigned BIT_CP_MID    = 7;
  localparam int unsigned BIT_RST_REF   = 6;
  localparam int unsigned BIT_RST_AB    = 5;
  localparam int unsigned BIT_RST_ALL   = 4;
  localparam int unsigned BIT_BYPASS    = 3;
  localparam int unsigned PSC_MSB       = 2;
  localparam int unsigned PSC_LSB       = 0;
  localparam int unsigned ST_AB_HELD    = 0;
  localparam int unsigned ST_REF_HELD   = 1;
  localparam int unsigned ST_HI_MOD     = 2;
  localparam int unsigned ST_DUAL       = 3;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0]            CTRL_RST    = 8'h06;
  localparam logic [SWALLOW_W-1:0]  SWALLOW_RST = 6'h00;
  localparam logic [MAIN_W-1:0]     MAIN_RST    = 13'h0003;
  localparam logic [REF_W-1:0]      REF_RST     = 14'h0001;

  // ==========================================================================
  // Prescaler mode codes.
  localparam logic [2:0] PSC_FD1   = 3'h0;
  localparam logic [2:0] PSC_FD2   = 3'h1;
  localparam logic [2:0] PSC_DM2   = 3'h2;
  localparam logic [2:0] PSC_DM4   = 3'h3;
  localparam logic [2:0] PSC_DM8   = 3'h4;
  localparam logic [2:0] PSC_DM16  = 3'h5;
  localparam logic [2:0] PSC_DM32  = 3'h6;
  localparam logic [2:0] PSC_FD3   = 3'h7;
  localparam logic [PSC_CNT_W-1:0] RATIO_1  = 6'h01;
  localparam logic [PSC_CNT_W-1:0] RATIO_2  = 6'h02;
  localparam logic [PSC_CNT_W-1:0] RATIO_3  = 6'h03;
  localparam logic [PSC_CNT_W-1:0] RATIO_4  = 6'h04;
  localparam logic [PSC_CNT_W-1:0] RATIO_8  = 6'h08;
  localparam logic [PSC_CNT_W-1:0] RATIO_16 = 6'h10;
  localparam logic [PSC_CNT_W-1:0] RATIO_32 = 6'h20;

  // Base ratio of the prescaler for a mode code.
  function automatic logic [PSC_CNT_W-1:0] psc_base(input logic [2:0] code);
    logic [PSC_CNT_W-1:0] r;
    r = RATIO_1;
    case (code)
      PSC_FD1:  r = RATIO_1;
      PSC_FD2:  r = RATIO_2;
      PSC_DM2:  r = RATIO_2;
      PSC_DM4:  r = RATIO_4;
      PSC_DM8:  r = RATIO_8;
      PSC_DM16: r = RATIO_16;
      PSC_DM32: r = RATIO_32;
      default:  r = RATIO_3;
    endcase
    return r;
  endfunction

  // True for the dual-modulus codes.
  function automatic logic psc_dual(input logic [2:0] code);
    return (code != PSC_FD1) && (code != PSC_FD2) && (code != PSC_FD3);
  endfunction

endpackage

/* File: prescaler_stage.sv */
// Prescaler stage: divides a tick stream by a selectable ratio.
`timescale 1ns/1ps
module prescaler_stage #(
  parameter int unsigned CNT_W = fbdiv_pkg::PSC_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] ratio,
  output logic                  pulse
);
  import fbdiv_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             pulse;
  } psc_state_t;

  psc_state_t s_r;
  psc_state_t s_nxt;

  // ==========================================================================
  // Counter: one pulse every ratio ticks; a ratio of one passes every tick.
  always_comb begin
    s_nxt       = s_r;
    s_nxt.pulse = 1'b0;
    if (clear) begin
      s_nxt.cnt = '0;
    end else if (tick) begin
      if (CNT_W'(s_r.cnt + 1'b1) >= ratio) begin
        s_nxt.cnt   = '0;
        s_nxt.pulse = 1'b1;
      end else begin
        s_nxt.cnt = CNT_W'(s_r.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pulse = s_r.pulse;

endmodule

/* File: feedback_divider_control.sv */
// PLL feedback divider with its control register and Avalon-MM slave.
//
// Behaviour
// - The prescaler is one stage of the feedback divider, so the feedback ratio depends on it and on both counters.
// - With the main-counter bypass bit 3 clear, its reset state, the main counter divides by its programmed value.
// - With the bypass bit set, the main counter divides by one and the prescaler alone sets the feedback ratio.
// - In 2/3 mode the prescaler mixes divide by 2 and 3 while the swallow count is nonzero, else divides by 2.
// - In 4/5 mode the prescaler mixes divide by 4 and 5 while the swallow count is nonzero, else divides by 4.
// - In 8/9 mode the prescaler mixes divide by 8 and 9 while the swallow count is nonzero, else divides by 8.
// - In 16/17 mode it mixes divide by 16 and 17 while the swallow count is nonzero, else divides by 16.
// - In 32/33 mode it mixes divide by 32 and 33 while the swallow count is nonzero, else divides by 32.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module feedback_divider_control (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [fbdiv_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [fbdiv_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [fbdiv_pkg::DATA_W-1:0] avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        osc_in,
  input  wire logic                        ref_in,
  output logic                             ref_div_pulse,
  output logic                             fb_div_pulse,
  output logic                             cp_mid_level
);
  import fbdiv_pkg::*;

  typedef struct packed {
    logic                 ack;
    logic [DATA_W-1:0]    rdata;
    logic [CTRL_W-1:0]    ctrl;
    logic [SWALLOW_W-1:0] swallow;
    logic [MAIN_W-1:0]    main_div;
    logic [REF_W-1:0]     ref_div;
    logic [2:0]           osc_sync;
    logic                 osc_lvl;
    logic [2:0]           ref_sync;
    logic                 ref_lvl;
    logic [REF_W-1:0]     ref_cnt;
    logic [SWALLOW_W-1:0] a_cnt;
    logic [MAIN_W-1:0]    b_cnt;
    logic                 ref_pulse;
    logic                 fb_pulse;
  } top_state_t;

  top_state_t s_r;
  top_state_t s_nxt;

  logic                 req;
  logic [IDX_W-1:0]     idx;
  logic                 be0;
  logic [7:0]           wbyte;
  logic                 ab_hold;
  logic                 ref_hold;
  logic                 bypass;
  logic [2:0]           psc_code;
  logic                 dual;
  logic                 hi_mod;
  logic [PSC_CNT_W-1:0] psc_ratio;
  logic                 osc_edge;
  logic                 ref_edge;
  logic                 psc_pulse;
  logic [DATA_W-1:0]    status_word;

  // ==========================================================================
  // Decode of the control fields.
  assign req      = avs_read | avs_write;
  assign idx      = avs_address[ADDR_W-1:2];
  assign be0      = avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];
  assign bypass   = s_r.ctrl[BIT_BYPASS];
  assign psc_code = s_r.ctrl[PSC_MSB:PSC_LSB];
  assign ab_hold  = s_r.ctrl[BIT_RST_AB] | s_r.ctrl[BIT_RST_ALL];
  assign ref_hold = s_r.ctrl[BIT_RST_REF] | s_r.ctrl[BIT_RST_ALL];
  assign dual     = psc_dual(psc_code);

  // The extra count is taken only in dual-modulus modes while swallow
  // cycles remain, so a zero swallow value leaves the base ratio alone.
  assign hi_mod    = dual && (s_r.a_cnt != '0);
  assign psc_ratio = PSC_CNT_W'(psc_base(psc_code) + {5'h00, hi_mod});

  // A rising pin edge counts once the second and third stages agree on a new high level.
  assign osc_edge = (s_r.osc_sync[1] == s_r.osc_sync[2]) &&
                    s_r.osc_sync[2] && !s_r.osc_lvl;
  assign ref_edge = (s_r.ref_sync[1] == s_r.ref_sync[2]) &&
                    s_r.ref_sync[2] && !s_r.ref_lvl;

  assign status_word = {{(DATA_W-4){1'b0}}, dual, hi_mod, ref_hold, ab_hold};

  // ==========================================================================
  // Prescaler stage, cleared together with the swallow and main counters.
  prescaler_stage #(
    .CNT_W (PSC_CNT_W)
  ) prescaler_stage_i (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (ab_hold),
    .tick  (osc_edge),
    .ratio (psc_ratio),
    .pulse (psc_pulse)
  );

  // ==========================================================================
  // Next-state logic.
  always_comb begin
    s_nxt           = s_r;
    s_nxt.ref_pulse = 1'b0;
    s_nxt.fb_pulse  = 1'b0;

    // Bus slave: one wait cycle, then the access completes.
    s_nxt.ack = req && !s_r.ack;
    if (avs_read && !s_r.ack) begin
      if (idx == IDX_REF_LO) begin
        s_nxt.rdata = DATA_W'(s_r.ref_div[REF_LO_W-1:0]);
      end else if (idx == IDX_REF_HI) begin
        s_nxt.rdata = DATA_W'(s_r.ref_div[REF_W-1:REF_LO_W]);
      end else if (idx == IDX_SWALLOW) begin
        s_nxt.rdata = DATA_W'(s_r.swallow);
      end else if (idx == IDX_MAIN_LO) begin
        s_nxt.rdata = DATA_W'(s_r.main_div[MAIN_LO_W-1:0]);
      end else if (idx == IDX_MAIN_HI) begin
        s_nxt.rdata = DATA_W'(s_r.main_div[MAIN_W-1:MAIN_LO_W]);
      end else if (idx == IDX_CTRL) begin
        s_nxt.rdata = DATA_W'(s_r.ctrl);
      end else if (idx == IDX_STATUS) begin
        s_nxt.rdata = status_word;
      end else begin
        s_nxt.rdata = '0;
      end
    end
    if (avs_write && s_r.ack && be0) begin
      if (idx == IDX_REF_LO) begin
        s_nxt.ref_div[REF_LO_W-1:0] = wbyte;
      end else if (idx == IDX_REF_HI) begin
        s_nxt.ref_div[REF_W-1:REF_LO_W] = wbyte[REF_HI_W-1:0];
      end else if (idx == IDX_SWALLOW) begin
        s_nxt.swallow = wbyte[SWALLOW_W-1:0];
      end else if (idx == IDX_MAIN_LO) begin
        s_nxt.main_div[MAIN_LO_W-1:0] = wbyte;
      end else if (idx == IDX_MAIN_HI) begin
        s_nxt.main_div[MAIN_W-1:MAIN_LO_W] = wbyte[MAIN_HI_W-1:0];
      end else if (idx == IDX_CTRL) begin
        s_nxt.ctrl = wbyte;
      end
    end

    // Pin synchronisers and filtered levels.
    s_nxt.osc_sync = {s_r.osc_sync[1:0], osc_in};
    s_nxt.ref_sync = {s_r.ref_sync[1:0], ref_in};
    if (s_r.osc_sync[1] == s_r.osc_sync[2]) begin
      s_nxt.osc_lvl = s_r.osc_sync[2];
    end
    if (s_r.ref_sync[1] == s_r.ref_sync[2]) begin
      s_nxt.ref_lvl = s_r.ref_sync[2];
    end

    // Reference counter; a programmed zero acts as divide by one.
    if (ref_hold) begin
      s_nxt.ref_cnt = '0;
    end else if (ref_edge) begin
      if (REF_W'(s_r.ref_cnt + 1'b1) >= s_r.ref_div) begin
        s_nxt.ref_cnt   = '0;
        s_nxt.ref_pulse = 1'b1;
      end else begin
        s_nxt.ref_cnt = REF_W'(s_r.ref_cnt + 1'b1);
      end
    end

    // Swallow and main counters, stepped by each prescaler output so, in dual-modulus modes with bypass
    // clear, the feedback ratio comes to prescaler times main plus swallow.
    if (ab_hold) begin
      s_nxt.a_cnt = s_r.swallow;
      s_nxt.b_cnt = s_r.main_div;
    end else if (psc_pulse) begin
      if (bypass || s_r.b_cnt <= MAIN_W'(1)) begin
        s_nxt.fb_pulse = 1'b1;
        s_nxt.a_cnt    = s_r.swallow;
        s_nxt.b_cnt    = s_r.main_div;
      end else begin
        s_nxt.b_cnt = MAIN_W'(s_r.b_cnt - 1'b1);
        if (s_r.a_cnt != '0) begin
          s_nxt.a_cnt = SWALLOW_W'(s_r.a_cnt - 1'b1);
        end
      end
    end
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.ctrl     <= CTRL_RST;
      s_r.swallow  <= SWALLOW_RST;
      s_r.main_div <= MAIN_RST;
      s_r.ref_div  <= REF_RST;
      s_r.a_cnt    <= SWALLOW_RST;
      s_r.b_cnt    <= MAIN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs.
  assign avs_waitrequest = req && !s_r.ack;
  assign avs_readdata    = s_r.rdata;
  assign ref_div_pulse   = s_r.ref_pulse;
  assign fb_div_pulse    = s_r.fb_pulse;
  assign cp_mid_level    = s_r.ctrl[BIT_CP_MID];

endmodule

/* File: fbdiv_checker_assertions.sv */
// Bus timing and divider output checks for the feedback divider block.
`timescale 1ns/1ps
module fbdiv_checker
  import fbdiv_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              ref_div_pulse,
  input wire logic              fb_div_pulse,
  input wire logic              cp_mid_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // =======
  // Tracks the combined hold bit as software writes it.
  logic       wr_ctrl;
  logic       held_r;
  logic [4:0] hcnt_r;
  assign wr_ctrl = avs_write && !avs_waitrequest && avs_byteenable[0]
                   && (avs_address[ADDR_W-1:2] == IDX_CTRL);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_r <= 1'h0;
      hcnt_r <= 5'h00;
    end else begin
      if (wr_ctrl) begin
        held_r <= avs_writedata[BIT_RST_ALL];
      end
      hcnt_r <= !held_r ? 5'h00 : (hcnt_r == 5'h1F) ? hcnt_r : hcnt_r + 5'h01;
    end
  end
  // =======
  // Properties.
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request waited over one cycle");
  wait_first_a: assert property ((avs_read || avs_write) && !avs_waitrequest
    |=> avs_waitrequest || !(avs_read || avs_write))
    else $error("no wait cycle on a new request");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  rdata_hold_a: assert property (!(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata)) else $error("read data moved between reads");
  cp_level_a: assert property (wr_ctrl ##1 !wr_ctrl [*2]
    |-> cp_mid_level == $past(avs_writedata[BIT_CP_MID], 3))
    else $error("charge pump level not from control bit");
  fb_width_a: assert property (fb_div_pulse |=> !fb_div_pulse)
    else $error("feedback pulse wider than one cycle");
  ref_width_a: assert property (ref_div_pulse |=> !ref_div_pulse)
    else $error("reference pulse wider than one cycle");
  hold_quiet_a: assert property (hcnt_r == 5'h1F
    |-> !fb_div_pulse && !ref_div_pulse) else $error("pulse while held");
endmodule
bind feedback_divider_control fbdiv_checker fbdiv_checker_i (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse),
  .cp_mid_level(cp_mid_level));

/* File: feedback_divider_control_tb_top.sv */
// Self-checking bench for the feedback divider control block.
`timescale 1ns/1ps
module feedback_divider_control_tb_top;
  import fbdiv_pkg::*;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              osc_in;
  logic              ref_in;
  logic              ref_div_pulse;
  logic              fb_div_pulse;
  logic              cp_mid_level;
  int                mismatches = 0;
  int                checks_done = 0;
  int                cyc = 0;
  logic [31:0]       seed;
  logic [31:0]       q;
  feedback_divider_control feedback_divider_control_i (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .osc_in(osc_in), .ref_in(ref_in), .ref_div_pulse(ref_div_pulse),
    .fb_div_pulse(fb_div_pulse), .cp_mid_level(cp_mid_level));
  // =======
  // Clock, pin stimulus and timeout; the oscillator pin has a 4-cycle period.
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    osc_in <= cyc[1];
    ref_in <= cyc[2];
    if (cyc == 60000) begin
      mismatches++;
      end_sim();
    end
  end
  // =======
  // Helpers.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_n(input int c, input logic byp, input int b,
                               input int a);
    int p;
    p = (c == 0) ? 1 : (c < 3) ? 2 : (c == 7) ? 3 : (4 << (c - 3));
    return p * ((byp || b < 2) ? 1 : b) + ((c >= 2 && c <= 6) ? a : 0);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d, input logic [3:0] be);
    logic w;
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= {idx, 2'h0};
    avs_writedata <= d;
    avs_byteenable <= be;
    // The settled waitrequest of each cycle decides at the edge closing it.
    do begin
      @(negedge clk);
      w = avs_waitrequest;
      @(posedge clk);
    end while (w !== 1'h0);
    q = avs_readdata;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'h0, idx, 32'h0, 4'hF);
    chk(q, exp);
  endtask
  task automatic idle();
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask
  // Cycles between two feedback pulses, or reference pulses when sel is set, ending just after a rising edge.
  task automatic per(input logic sel, output int t);
    int n;
    n = 0;
    t = 0;
    @(negedge clk);
    while ((sel ? ref_div_pulse : fb_div_pulse) !== 1'h1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    do begin
      @(negedge clk);
      t++;
    end while ((sel ? ref_div_pulse : fb_div_pulse) !== 1'h1 && t < 2000);
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // =======
  // Main sequence.
  initial begin
    int t;
    int b;
    int a;
    int n;
    logic [7:0] c;
    seed = 32'h0000762A;
    {avs_read, avs_write} = 2'h0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    rst_n = 1'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(IDX_CTRL, {24'h0, CTRL_RST});
    rd(IDX_SWALLOW, 32'h0);
    rd(IDX_MAIN_LO, 32'h3);
    rd(IDX_STATUS, 32'h8);
    bus(1'h1, IDX_REF_LO, 32'h3, 4'hF);
    rd(IDX_REF_LO, 32'h3);
    bus(1'h1, 8'h30, 32'hFF, 4'hF);
    rd(8'h30, 32'h0);
    bus(1'h1, IDX_CTRL, 32'h1F, 4'hE);
    rd(IDX_CTRL, {24'h0, CTRL_RST});
    idle();
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      b = int'(rnd() % 5);
      a = i[0] ? 0 : int'(rnd() % ((b < 2) ? 2 : b + 1));
      c = 8'(rnd() & 32'h80) | {4'h0, i[0], i[3:1]};
      bus(1'h1, IDX_CTRL, 32'h10, 4'hF);
      bus(1'h1, IDX_MAIN_LO, b, 4'hF);
      bus(1'h1, IDX_MAIN_HI, 32'h0, 4'hF);
      bus(1'h1, IDX_SWALLOW, a, 4'hF);
      bus(1'h1, IDX_CTRL, c, 4'hF);
      rd(IDX_CTRL, {24'h0, c});
      idle();
      chk({31'h0, cp_mid_level}, {31'h0, c[7]});
      per(1'h0, t);
      per(1'h0, t);
      chk(t, 4 * exp_n(i / 2, i[0], b, a));
    end
    $display("test ratios done"); // covered in loop
    bus(1'h1, IDX_CTRL, 32'h16, 4'hF);
    bus(1'h1, IDX_MAIN_LO, 32'h2, 4'hF);
    bus(1'h1, IDX_SWALLOW, 32'h1, 4'hF);
    idle();
    repeat (40) @(posedge clk);
    n = 0;
    repeat (400) begin
      @(negedge clk);
      n += (fb_div_pulse !== 1'h0) + (ref_div_pulse !== 1'h0);
    end
    chk(n, 0);
    @(posedge clk);
    bus(1'h1, IDX_CTRL, 32'h06, 4'hF);
    idle();
    per(1'h0, t);
    per(1'h0, t);
    chk(t, 4 * (32 * 2 + 1));
    // Reference pin has an 8-cycle period and the divider was set to 3.
    per(1'h1, t);
    per(1'h1, t);
    chk(t, 8 * 3);
    $display("test hold done");
    end_sim();
  end
endmodule
